// ---- rtl/irq_sel_map.svh ----
`ifndef IRQ_SEL_MAP_SVH
`define IRQ_SEL_MAP_SVH
// register indices as printed; byte address is four times the index
`define IDX_IRQ_ENABLE 8'h3f
`define IDX_IRQ_LINE_SOURCE_SELECT 8'h41
`define IDX_IRQ_FLAG_CLEAR 8'h42
`define IDX_IRQ_FLAG_STATUS 8'h43
`define IDX_DEVICE_STATE 8'h50
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_LINE_SOURCE_SELECT 8'h00
`define RST_IRQ_FLAG_STATUS 8'h00
`define SEL_TWO_HI 7
`define SEL_TWO_LO 4
`define SEL_ONE_HI 3
`define SEL_ONE_LO 0
`define FLG_SLEEP 7
`define FLG_RXTMO 6
`define FLG_RSSI 5
`define FLG_PREAM 4
`define FLG_SYNC 3
`define FLG_ADDR 2
`define FLG_CSUM 1
`define FLG_FRAME 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- rtl/irq_sel_pkg.sv ----
package irq_sel_pkg;
  typedef enum logic [1:0] {MODE_DIRECT, MODE_BUFFER, MODE_PACKET, MODE_RSVD} data_mode_t;
  typedef enum logic [2:0] {
    ST_SLEEP, ST_STANDBY, ST_TUNE, ST_RECEIVE, ST_NVM, ST_OTHER
  } dev_state_t;
  // event vector index order used by the selector
  typedef struct packed {
    logic rssiValid;
    logic preamble;
    logic syncword;
    logic addrMatch;
    logic checksum;
    logic frame;
    logic sleepTmo;
    logic rxTmo;
    logic rssiInd;
    logic qNotEmpty;
    logic qThresh;
    logic qFull;
    logic qWrite;
    logic qOvf;
  } irq_src_t;
endpackage

// ---- rtl/irq_src_if.sv ----
`timescale 1ns/1ps
interface irq_src_if;
  irq_sel_pkg::irq_src_t src;
  irq_sel_pkg::data_mode_t mode;
  logic [3:0] selOne;
  logic [3:0] selTwo;
  logic lineOne;
  logic lineTwo;
  modport ctrl (output src, output mode, output selOne, output selTwo, input lineOne,
    input lineTwo);
  modport mux (input src, input mode, input selOne, input selTwo, output lineOne,
    output lineTwo);
endinterface

// ---- rtl/irq_source_mux.sv ----
`timescale 1ns/1ps
module irq_source_mux (
  irq_src_if.mux bus
);
  function automatic logic pick(input logic [3:0] code, input irq_sel_pkg::data_mode_t m,
      input irq_sel_pkg::irq_src_t s);
    logic r;
    r = 1'b0;
    unique case (code)
      4'h0: r = 1'b0;
      4'h1: r = s.rssiValid;
      4'h2: r = s.preamble;
      4'h3: r = s.syncword;
      default: begin
        if (m == irq_sel_pkg::MODE_DIRECT) begin
          unique case (code)
            4'h4: r = s.sleepTmo;
            4'h5: r = s.rxTmo;
            4'h6: r = s.rssiInd;
            default: r = 1'b0;
          endcase
        end else if (m == irq_sel_pkg::MODE_BUFFER) begin
          unique case (code)
            4'h4: r = s.sleepTmo;
            4'h5: r = s.rxTmo;
            4'h6: r = s.qNotEmpty;
            4'h7: r = s.qThresh;
            4'h8: r = s.qFull;
            4'h9: r = s.qWrite;
            4'ha: r = s.qOvf;
            4'hb: r = s.rssiInd;
            default: r = 1'b0;
          endcase
        end else if (m == irq_sel_pkg::MODE_PACKET) begin
          unique case (code)
            4'h4: r = s.addrMatch;
            4'h5: r = s.checksum;
            4'h6: r = s.frame;
            4'h7: r = s.sleepTmo;
            4'h8: r = s.rxTmo;
            4'h9: r = s.qNotEmpty;
            4'ha: r = s.qThresh;
            4'hb: r = s.qFull;
            4'hc: r = s.qWrite;
            4'hd: r = s.qOvf;
            4'he: r = s.rssiInd;
            default: r = 1'b0;
          endcase
        end
      end
    endcase
    return r;
  endfunction

  assign bus.lineTwo = pick(bus.selTwo, bus.mode, bus.src);
  assign bus.lineOne = pick(bus.selOne, bus.mode, bus.src);
endmodule

// ---- rtl/rx_interrupt_select_and_flags.sv ----
`timescale 1ns/1ps
`include "irq_sel_map.svh"
module rx_interrupt_select_and_flags (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] dataMode,
  input wire logic [2:0] deviceState,
  input wire logic fskActive,
  input wire logic sleepTimerOn,
  input wire logic rxTimerOn,
  input wire logic rssiValidEvent,
  input wire logic preamblePass,
  input wire logic syncwordPass,
  input wire logic addressMatchPass,
  input wire logic checksumPass,
  input wire logic frameReceived,
  input wire logic sleepTimeout,
  input wire logic receiveTimeout,
  input wire logic rssiIndicator,
  input wire logic queueNotEmpty,
  input wire logic queueThreshold,
  input wire logic queueFullEvent,
  input wire logic queueByteWriteStrobe,
  input wire logic queueOverflow,
  output logic irqLineOne,
  output logic irqLineTwo
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] enable_reg;
  logic [7:0] select_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awIdx_reg;
  logic [7:0] wData_reg;
  logic wLane_reg;
  logic clearWindow;
  logic packetMode;
  logic doWrite;
  logic [7:0] arIdx;
  irq_sel_pkg::dev_state_t devState;
  irq_src_if srcBus ();

  assign devState = irq_sel_pkg::dev_state_t'(deviceState);
  assign packetMode = dataMode == 2'(irq_sel_pkg::MODE_PACKET);

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken independently, response after both
  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      awIdx_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awIdx_reg <= s_axi_awaddr[9:2];
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 8'h00;
      wLane_reg <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata[7:0];
        wLane_reg <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      case (awIdx_reg)
        `IDX_IRQ_ENABLE, `IDX_IRQ_LINE_SOURCE_SELECT, `IDX_IRQ_FLAG_CLEAR:
          s_axi_bresp <= `RESP_OKAY;
        default: s_axi_bresp <= `RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      enable_reg <= `RST_IRQ_ENABLE;
    end else if (doWrite && wLane_reg && awIdx_reg == `IDX_IRQ_ENABLE) begin
      enable_reg <= wData_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      select_reg <= `RST_IRQ_LINE_SOURCE_SELECT;
    end else if (doWrite && wLane_reg && awIdx_reg == `IDX_IRQ_LINE_SOURCE_SELECT) begin
      select_reg <= wData_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags
  always_comb begin
    unique case (devState)
      irq_sel_pkg::ST_STANDBY, irq_sel_pkg::ST_TUNE, irq_sel_pkg::ST_RECEIVE,
      irq_sel_pkg::ST_NVM: clearWindow = 1'b1;
      default: clearWindow = 1'b0;
    endcase
  end

  always_comb begin
    setVec[`FLG_SLEEP] = sleepTimeout && sleepTimerOn;
    setVec[`FLG_RXTMO] = receiveTimeout && rxTimerOn;
    setVec[`FLG_RSSI] = rssiValidEvent && fskActive;
    setVec[`FLG_PREAM] = preamblePass;
    setVec[`FLG_SYNC] = syncwordPass;
    setVec[`FLG_ADDR] = addressMatchPass && packetMode;
    setVec[`FLG_CSUM] = checksumPass && packetMode;
    setVec[`FLG_FRAME] = frameReceived && packetMode;
    setVec = setVec & enable_reg;
  end

  // write-only register: a write never lands in storage; it clears flags only in standby, tune, receive or NVM state
  assign clrVec = (doWrite && wLane_reg && clearWindow && awIdx_reg == `IDX_IRQ_FLAG_CLEAR)
    ? wData_reg : 8'h00;

  // set wins over a clear in the same cycle so no event is lost
  assign flag_next = (flag_reg & ~clrVec) | setVec;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_reg <= `RST_IRQ_FLAG_STATUS;
    end else begin
      flag_reg <= flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel, one cycle after address acceptance
  assign arIdx = s_axi_araddr[9:2];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (arIdx)
          `IDX_IRQ_ENABLE: s_axi_rdata <= {24'h000000, enable_reg};
          `IDX_IRQ_LINE_SOURCE_SELECT: s_axi_rdata <= {24'h000000, select_reg};
          `IDX_IRQ_FLAG_CLEAR: s_axi_rdata <= 32'h0000_0000;
          `IDX_IRQ_FLAG_STATUS: s_axi_rdata <= {24'h000000, flag_reg};
          `IDX_DEVICE_STATE: s_axi_rdata <= {28'h0000000, dataMode == 2'h3, deviceState};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line routing; the write strobe passes through as a pulse with no flag
  assign srcBus.src = '{
    rssiValid: rssiValidEvent, preamble: preamblePass, syncword: syncwordPass,
    addrMatch: addressMatchPass, checksum: checksumPass, frame: frameReceived,
    sleepTmo: sleepTimeout, rxTmo: receiveTimeout, rssiInd: rssiIndicator,
    qNotEmpty: queueNotEmpty, qThresh: queueThreshold, qFull: queueFullEvent,
    qWrite: queueByteWriteStrobe, qOvf: queueOverflow};
  assign srcBus.mode = irq_sel_pkg::data_mode_t'(dataMode);
  assign srcBus.selTwo = select_reg[`SEL_TWO_HI:`SEL_TWO_LO];
  assign srcBus.selOne = select_reg[`SEL_ONE_HI:`SEL_ONE_LO];

  irq_source_mux muxInst (
    .bus(srcBus.mux)
  );

  // registered so the pins are glitch free; costs one cycle of latency
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqLineOne <= 1'b0;
      irqLineTwo <= 1'b0;
    end else begin
      irqLineOne <= srcBus.lineOne;
      irqLineTwo <= srcBus.lineTwo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_CLEAR_OUTSIDE_WINDOW:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (flag_reg[`FLG_FRAME] && !clearWindow && !setVec[`FLG_FRAME])
      |=> flag_reg[`FLG_FRAME])
    else $error("flag cleared outside clear window");
  AST_CLEAR_TAKES:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clrVec[`FLG_SYNC] && !setVec[`FLG_SYNC]) |=> !flag_reg[`FLG_SYNC])
    else $error("clear write did not clear flag");
  AST_FLAG_STICKY:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (flag_reg[`FLG_PREAM] && !clrVec[`FLG_PREAM]) |=> flag_reg[`FLG_PREAM])
    else $error("flag dropped without clear");
  AST_SLEEP_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sleepTimeout && sleepTimerOn && enable_reg[`FLG_SLEEP]) |=> flag_reg[`FLG_SLEEP])
    else $error("sleep flag not set");
  AST_RXTMO_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (receiveTimeout && rxTimerOn && enable_reg[`FLG_RXTMO]) |=> flag_reg[`FLG_RXTMO])
    else $error("receive timeout flag not set");
  AST_RSSI_NEEDS_FSK:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!flag_reg[`FLG_RSSI] && !fskActive) |=> !flag_reg[`FLG_RSSI])
    else $error("rssi flag set without fsk");
  AST_ADDR_PACKET_ONLY:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!flag_reg[`FLG_ADDR] && !packetMode) |=> !flag_reg[`FLG_ADDR])
    else $error("address flag set outside packet mode");
  AST_ENABLE_GATES:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!flag_reg[`FLG_CSUM] && !enable_reg[`FLG_CSUM]) |=> !flag_reg[`FLG_CSUM])
    else $error("flag set while disabled");
  AST_LINE_TWO_FOLLOWS:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_TWO_HI:`SEL_TWO_LO] == 4'h2 && $stable(select_reg))
      |=> irqLineTwo == $past(preamblePass))
    else $error("line two not following preamble");
  AST_CODE15_ZERO:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_ONE_HI:`SEL_ONE_LO] == 4'hf) |=> !irqLineOne)
    else $error("code fifteen not zero");
  AST_PREAM_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (preamblePass && enable_reg[`FLG_PREAM]) |=> flag_reg[`FLG_PREAM])
    else $error("preamble flag not set");
  AST_SYNC_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (syncwordPass && enable_reg[`FLG_SYNC]) |=> flag_reg[`FLG_SYNC])
    else $error("sync word flag not set");
  AST_ADDR_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (addressMatchPass && packetMode && enable_reg[`FLG_ADDR]) |=> flag_reg[`FLG_ADDR])
    else $error("address flag not set");
  AST_CSUM_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (checksumPass && packetMode && enable_reg[`FLG_CSUM]) |=> flag_reg[`FLG_CSUM])
    else $error("checksum flag not set");
  AST_FRAME_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (frameReceived && packetMode && enable_reg[`FLG_FRAME]) |=> flag_reg[`FLG_FRAME])
    else $error("frame flag not set");
  AST_FRAME_PACKET_ONLY:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!flag_reg[`FLG_FRAME] && !packetMode) |=> !flag_reg[`FLG_FRAME])
    else $error("frame flag set outside packet mode");
  AST_SLEEP_NEEDS_TIMER:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!flag_reg[`FLG_SLEEP] && !sleepTimerOn) |=> !flag_reg[`FLG_SLEEP])
    else $error("sleep flag set with timer off");
  AST_RXTMO_NEEDS_TIMER:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!flag_reg[`FLG_RXTMO] && !rxTimerOn) |=> !flag_reg[`FLG_RXTMO])
    else $error("receive timeout flag set with timer off");
  AST_RSSI_SET:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rssiValidEvent && fskActive && enable_reg[`FLG_RSSI]) |=> flag_reg[`FLG_RSSI])
    else $error("rssi flag not set");
  AST_CODE_ZERO_ZERO:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_TWO_HI:`SEL_TWO_LO] == 4'h0) |=> !irqLineTwo)
    else $error("code zero not zero on line two");
  AST_LINE_ONE_FOLLOWS:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_ONE_HI:`SEL_ONE_LO] == 4'h3) |=> irqLineOne == $past(syncwordPass))
    else $error("line one not following sync word");
  AST_STROBE_ON_LINE:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_TWO_HI:`SEL_TWO_LO] == 4'h9 && dataMode == 2'(irq_sel_pkg::MODE_BUFFER))
      |=> irqLineTwo == $past(queueByteWriteStrobe))
    else $error("write strobe not on line two");
  AST_PACKET_CODE14:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_TWO_HI:`SEL_TWO_LO] == 4'he && packetMode)
      |=> irqLineTwo == $past(rssiIndicator))
    else $error("packet code fourteen not rssi indicator");
  AST_DIRECT_HIGH_ZERO:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_TWO_HI:`SEL_TWO_LO] >= 4'h7 && dataMode == 2'(irq_sel_pkg::MODE_DIRECT))
      |=> !irqLineTwo)
    else $error("direct mode high code not zero");
  AST_BUFFER_HIGH_ZERO:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      (select_reg[`SEL_TWO_HI:`SEL_TWO_LO] >= 4'hc && dataMode == 2'(irq_sel_pkg::MODE_BUFFER))
      |=> !irqLineTwo)
    else $error("buffer mode high code not zero");
endmodule

// ---- verification/mcu_model.sv ----
`timescale 1ns/1ps
module mcu_model (
  input wire logic clk,
  output logic [9:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [9:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  int tmo = 0;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  ////////////////////////////////////////////////////////////////
  // handshakes judged at the falling edge so rising-edge updates never race
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic a, w, b;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) tmo++;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic a, v;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      a = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (v) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) tmo++;
  endtask
endmodule

// ---- verification/rx_interrupt_select_and_flags_test.sv ----
`timescale 1ns/1ps
`include "irq_sel_map.svh"
module rx_interrupt_select_and_flags_test;
  logic clk_sys = 0;
  logic rst_n = 0;
  logic [1:0] dataMode = 2'h0;
  logic [2:0] deviceState = 3'h1;
  logic [2:0] qual = 3'h0;
  // 7:0 flag events in status bit order, 13:8 line-only sources
  logic [13:0] s = '0;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irqLineOne, irqLineTwo;
  int n_errors = 0;
  int checks_done = 0;
  int seed = 24894;
  logic [7:0] e;
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  mcu_model mcu_model_i (.clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  rx_interrupt_select_and_flags rx_interrupt_select_and_flags_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dataMode(dataMode), .deviceState(deviceState), .fskActive(qual[2]),
    .sleepTimerOn(qual[1]), .rxTimerOn(qual[0]), .rssiValidEvent(s[5]),
    .preamblePass(s[4]), .syncwordPass(s[3]), .addressMatchPass(s[2]),
    .checksumPass(s[1]), .frameReceived(s[0]), .sleepTimeout(s[7]),
    .receiveTimeout(s[6]), .rssiIndicator(s[8]), .queueNotEmpty(s[9]),
    .queueThreshold(s[10]), .queueFullEvent(s[11]), .queueByteWriteStrobe(s[12]),
    .queueOverflow(s[13]), .irqLineOne(irqLineOne), .irqLineTwo(irqLineTwo));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    n_errors++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) fail($sformatf("read data %h expected %h", got, exp));
  endtask
  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) fail($sformatf("response %h expected %h", got, exp));
  endtask
  task automatic chkBit(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) fail($sformatf("%s is %b expected %b", m, got, exp));
  endtask
  task automatic hang();
    if (mcu_model_i.tmo != 0) begin
      fail("bus wait ran out");
      summarize();
    end
  endtask
  task automatic regW(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    mcu_model_i.wr(idx, d, r);
    hang();
    chkResp(r, `RESP_OKAY);
  endtask
  task automatic regR(input logic [7:0] idx, input logic [7:0] x, input logic [1:0] xr);
    logic [31:0] d;
    logic [1:0] r;
    mcu_model_i.rd(idx, d, r);
    hang();
    chkResp(r, xr);
    chkReg(d, {24'h0, x});
  endtask
  // one-cycle event burst, then status readback
  task automatic pulse(input logic [13:0] v, input logic [7:0] x);
    @(posedge clk_sys);
    s <= v;
    @(posedge clk_sys);
    s <= '0;
    regR(`IDX_IRQ_FLAG_STATUS, x, `RESP_OKAY);
  endtask
  function automatic logic pick(input int m, input int c, input logic [13:0] v);
    int i;
    i = -1;
    if (c >= 1 && c <= 3) i = 6 - c;
    else if (c >= 4 && m == 0) i = (c == 4) ? 7 : (c == 5) ? 6 : (c == 6) ? 8 : -1;
    else if (c >= 4 && m == 1)
      i = (c == 4) ? 7 : (c == 5) ? 6 : (c <= 10) ? c + 3 : (c == 11) ? 8 : -1;
    else if (c >= 4 && m == 2)
      i = (c <= 6) ? 6 - c : (c == 7) ? 7 : (c == 8) ? 6 : (c <= 13) ? c : (c == 14) ? 8 : -1;
    return (i < 0) ? 1'b0 : v[i];
  endfunction
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail("run too long");
    summarize();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    regR(`IDX_IRQ_ENABLE, 8'h00, `RESP_OKAY);
    regR(`IDX_IRQ_LINE_SOURCE_SELECT, 8'h00, `RESP_OKAY);
    regR(`IDX_IRQ_FLAG_STATUS, 8'h00, `RESP_OKAY);
    regR(`IDX_IRQ_FLAG_CLEAR, 8'h00, `RESP_OKAY);
    regR(8'h44, 8'h00, `RESP_SLVERR);
    // state readback is {mode is reserved, device state}
    regR(`IDX_DEVICE_STATE, {4'h0, 1'b0, 3'h1}, `RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 16; c++) begin
        regW(`IDX_IRQ_LINE_SOURCE_SELECT, {c[3:0], ~c[3:0]});
        regR(`IDX_IRQ_LINE_SOURCE_SELECT, {c[3:0], ~c[3:0]}, `RESP_OKAY);
        repeat (2) begin
          @(posedge clk_sys);
          dataMode <= m[1:0];
          s <= 14'($random(seed));
          qual <= 3'($random(seed));
          repeat (2) @(posedge clk_sys);
          @(negedge clk_sys);
          chkBit(irqLineTwo, pick(m, c, s), "line two");
          chkBit(irqLineOne, pick(m, 15 - c, s), "line one");
        end
      end
    end
    @(posedge clk_sys);
    s <= '0;
    qual <= 3'h7;
    dataMode <= 2'h2;
    regR(`IDX_IRQ_FLAG_STATUS, 8'h00, `RESP_OKAY);
    regW(`IDX_IRQ_ENABLE, 8'hff);
    regR(`IDX_IRQ_ENABLE, 8'hff, `RESP_OKAY);
    for (int b = 0; b < 8; b++) begin
      pulse(14'h1 << b, 8'h1 << b);
      regW(`IDX_IRQ_FLAG_CLEAR, 8'h1 << b);
      regR(`IDX_IRQ_FLAG_STATUS, 8'h00, `RESP_OKAY);
    end
    pulse(14'h10ff, 8'hff);
    e = 8'hff;
    for (int b = 0; b < 6; b++) begin
      @(posedge clk_sys);
      deviceState <= b[2:0];
      if (b >= 1 && b <= 4) e[b] = 1'b0;
      regW(`IDX_IRQ_FLAG_CLEAR, 8'h1 << b);
      regR(`IDX_IRQ_FLAG_STATUS, e, `RESP_OKAY);
    end
    @(posedge clk_sys);
    deviceState <= 3'h1;
    dataMode <= 2'h0;
    regW(`IDX_IRQ_FLAG_CLEAR, 8'hff);
    pulse(14'h00ff, 8'hf8);
    regW(`IDX_IRQ_FLAG_CLEAR, 8'hff);
    @(posedge clk_sys);
    dataMode <= 2'h2;
    qual <= 3'h0;
    pulse(14'h00ff, 8'h1f);
    regW(`IDX_IRQ_FLAG_CLEAR, 8'hff);
    regW(`IDX_IRQ_ENABLE, 8'h00);
    pulse(14'h3fff, 8'h00);
    summarize();
  end
endmodule
